//--- rgtc_cfg.svh
// Offsets, field positions and reset values of the gain and carrier registers
`ifndef RGTC_CFG_SVH
`define RGTC_CFG_SVH
`define RGTC_ADDR_W 8
`define RGTC_OFF_GAIN_CFG 8'h1e
`define RGTC_OFF_STATIC 8'h1f
`define RGTC_OFF_TXCTL 8'h20
`define RGTC_BIT_LOOP_EN 0
`define RGTC_BIT_FIXED_SEL 1
`define RGTC_BIT_LOAD 2
`define RGTC_BIT_SRC_SEL 3
`define RGTC_CARD_LSB 0
`define RGTC_CARD_MSB 9
`define RGTC_READER_LSB 10
`define RGTC_READER_MSB 19
`define RGTC_TX_BYPASS 12
`define RGTC_TX_RES_LSB 13
`define RGTC_TX_RES_MSB 17
`define RGTC_TX_FORCE 18
`define RGTC_TX_OVP_LSB 19
`define RGTC_TX_OVP_MSB 23
`define RGTC_TX_AMP_LSB 24
`define RGTC_TX_AMP_MSB 25
`define RGTC_TX_DRV 26
`define RGTC_LEVEL_RST 10'h000
`define RGTC_AMP_MAX 2'h3
`define RGTC_TAU_FAST 4'hf
`endif

//--- rgtc_pkg.sv
// Types of the gain and carrier register block
package rgtc_pkg;
   typedef struct packed
   {
      logic src_sel;
      logic fixed_sel;
      logic loop_en;
   } rgtc_gain_cfg_t;

   typedef struct packed
   {
      logic drv_single;
      logic [1:0] amp;
      logic [4:0] ovp_res;
      logic force_max;
      logic [4:0] res;
      logic bypass;
   } rgtc_txctl_t;

   typedef struct packed
   {
      rgtc_gain_cfg_t cfg;
      logic [9:0] reader_lvl;
      logic [9:0] card_lvl;
      rgtc_txctl_t tx;
      logic [9:0] loaded;
      logic [9:0] frozen;
      logic [9:0] divider;
      logic load_pend;
      logic [1:0] carrier_amp;
      logic [3:0] tau_eff;
      logic [31:0] rdata;
   } rgtc_state_t;
endpackage

//--- rgtc_regs.sv
// Gain divider and transmitter carrier configuration registers
`timescale 1ns/10ps
`include "rgtc_cfg.svh"
// ==========================================
module rgtc_regs
   import rgtc_pkg::*;
#(
   parameter int LEVEL_W = 10
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [`RGTC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Gain loop side
   input wire logic [LEVEL_W-1:0] loop_divider,
   output logic [LEVEL_W-1:0] rx_divider,
   output logic gain_loop_enable,
   // Transmitter side
   input wire logic [3:0] rising_edge_tau,
   output logic [3:0] tau_effective,
   output logic shaping_bypass,
   output logic load_mod_driver_select,
   output logic [1:0] card_carrier_amplitude,
   output logic [4:0] residual_level,
   output logic [4:0] overshoot_residual_level
);

   // ==========================================
   // Parameter check
   if (LEVEL_W != 10)
   begin
      $error("rgtc_regs: LEVEL_W must be 10");
   end

   rgtc_state_t s;
   rgtc_state_t next_s;
   logic [9:0] selected;

   function automatic logic hit(input logic [`RGTC_ADDR_W-1:0] a,
                                input logic [`RGTC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Read words of the register views; reserved positions stay zero
   function automatic logic [31:0] cfg_word(input rgtc_gain_cfg_t c);
      cfg_word = 32'h0000_0000;
      cfg_word[`RGTC_BIT_LOOP_EN] = c.loop_en;
      cfg_word[`RGTC_BIT_FIXED_SEL] = c.fixed_sel;
      cfg_word[`RGTC_BIT_SRC_SEL] = c.src_sel;
   endfunction

   function automatic logic [31:0] tx_word(input rgtc_txctl_t t);
      tx_word = 32'h0000_0000;
      tx_word[`RGTC_TX_DRV:`RGTC_TX_BYPASS] = t;
   endfunction

   // ==========================================
   // Next state
   always_comb
   begin
      next_s = s;
      // Level the source select currently picks
      selected = s.cfg.src_sel ? s.reader_lvl : s.card_lvl;
      next_s.load_pend = 1'b0;
      if (s.load_pend)
         next_s.loaded = selected;
      if (s.cfg.loop_en)
         next_s.frozen = loop_divider;
      if (reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG))
      begin
         next_s.cfg.loop_en = reg_wdata[`RGTC_BIT_LOOP_EN];
         next_s.cfg.fixed_sel = reg_wdata[`RGTC_BIT_FIXED_SEL];
         next_s.cfg.src_sel = reg_wdata[`RGTC_BIT_SRC_SEL];
         next_s.load_pend = reg_wdata[`RGTC_BIT_LOAD];
      end
      if (reg_wr && hit(reg_addr, `RGTC_OFF_STATIC))
      begin
         next_s.card_lvl = reg_wdata[`RGTC_CARD_MSB:`RGTC_CARD_LSB];
         next_s.reader_lvl = reg_wdata[`RGTC_READER_MSB:`RGTC_READER_LSB];
      end
      if (reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL))
      begin
         next_s.tx.drv_single = reg_wdata[`RGTC_TX_DRV];
         next_s.tx.amp = reg_wdata[`RGTC_TX_AMP_MSB:`RGTC_TX_AMP_LSB];
         next_s.tx.ovp_res = reg_wdata[`RGTC_TX_OVP_MSB:`RGTC_TX_OVP_LSB];
         next_s.tx.force_max = reg_wdata[`RGTC_TX_FORCE];
         next_s.tx.res = reg_wdata[`RGTC_TX_RES_MSB:`RGTC_TX_RES_LSB];
         next_s.tx.bypass = reg_wdata[`RGTC_TX_BYPASS];
      end
      // Divider: loop value when enabled, else fixed choice
      if (s.cfg.loop_en)
         next_s.divider = loop_divider;
      else if (s.cfg.fixed_sel)
         next_s.divider = s.frozen;
      else
         next_s.divider = s.loaded;
      next_s.carrier_amp = s.tx.force_max ? `RGTC_AMP_MAX : s.tx.amp;
      next_s.tau_eff = s.tx.bypass ? `RGTC_TAU_FAST : rising_edge_tau;
      // Read data one cycle after the strobe; strobe and reserved read zero
      next_s.rdata = 32'h0000_0000;
      if (reg_rd && hit(reg_addr, `RGTC_OFF_GAIN_CFG))
         next_s.rdata = cfg_word(s.cfg);
      else if (reg_rd && hit(reg_addr, `RGTC_OFF_STATIC))
         next_s.rdata[`RGTC_READER_MSB:`RGTC_CARD_LSB] = {s.reader_lvl, s.card_lvl};
      else if (reg_rd && hit(reg_addr, `RGTC_OFF_TXCTL))
         next_s.rdata = tx_word(s.tx);
   end

   // ==========================================
   // State register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign rx_divider = s.divider;
   assign gain_loop_enable = s.cfg.loop_en;
   assign tau_effective = s.tau_eff;
   assign shaping_bypass = s.tx.bypass;
   assign load_mod_driver_select = s.tx.drv_single;
   assign card_carrier_amplitude = s.carrier_amp;
   assign residual_level = s.tx.res;
   assign overshoot_residual_level = s.tx.ovp_res;

   // ==========================================
   // Checks
   a_load_copies_level: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.load_pend |=> s.loaded == $past(selected))
      else $error("load did not copy selected level");
   a_strobe_self_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.load_pend && !(reg_wr && reg_addr == `RGTC_OFF_GAIN_CFG) |=> !s.load_pend)
      else $error("load strobe stuck");
   a_fixed_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.cfg.loop_en && !s.cfg.fixed_sel |=> rx_divider == $past(s.loaded))
      else $error("fixed divider not selected level");
   a_frozen_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.cfg.loop_en && s.cfg.fixed_sel |=> rx_divider == $past(s.frozen))
      else $error("frozen divider not held");
   a_select_no_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.load_pend |=> s.loaded == $past(s.loaded))
      else $error("divider value changed without load");
   a_loop_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.cfg.loop_en |=> rx_divider == $past(loop_divider))
      else $error("loop divider not followed");
   a_force_max_amp: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.tx.force_max |=> card_carrier_amplitude == `RGTC_AMP_MAX)
      else $error("force max ignored");
   a_bypass_tau: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.tx.bypass |=> tau_effective == `RGTC_TAU_FAST)
      else $error("bypass did not give fastest rise");
   a_strobe_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `RGTC_OFF_GAIN_CFG |=> reg_rdata[`RGTC_BIT_LOAD] == 1'b0)
      else $error("load strobe read nonzero");

   // ==========================================
   // Gain configuration checks
   a_cfg_loop_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG)
      |=> gain_loop_enable == $past(reg_wdata[`RGTC_BIT_LOOP_EN]))
      else $error("loop enable write lost");

   a_cfg_fixed_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG)
      |=> s.cfg.fixed_sel == $past(reg_wdata[`RGTC_BIT_FIXED_SEL]))
      else $error("fixed select write lost");

   a_cfg_src_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG)
      |=> s.cfg.src_sel == $past(reg_wdata[`RGTC_BIT_SRC_SEL]))
      else $error("source select write lost");

   a_cfg_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG))
      |=> $stable(s.cfg))
      else $error("gain config changed without write");

   a_load_arms: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG) && reg_wdata[`RGTC_BIT_LOAD]
      |=> s.load_pend)
      else $error("load strobe not taken");

   a_load_needs_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(reg_wr && hit(reg_addr, `RGTC_OFF_GAIN_CFG) && reg_wdata[`RGTC_BIT_LOAD])
      |=> !s.load_pend)
      else $error("load raised without strobe");

   a_load_reader: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.load_pend && s.cfg.src_sel
      |=> s.loaded == $past(s.reader_lvl))
      else $error("load did not take reader level");

   a_load_card: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.load_pend && !s.cfg.src_sel
      |=> s.loaded == $past(s.card_lvl))
      else $error("load did not take card level");

   a_loop_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.cfg.loop_en
      |=> s.frozen == $past(loop_divider))
      else $error("frozen value not tracking loop");

   a_frozen_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.cfg.loop_en
      |=> $stable(s.frozen))
      else $error("frozen value moved with loop off");

   a_cfg_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_GAIN_CFG)
      |=> reg_rdata == $past(cfg_word(s.cfg)))
      else $error("gain config read wrong");

   a_cfg_read_rsvd: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_GAIN_CFG)
      |=> (reg_rdata >> (`RGTC_BIT_SRC_SEL + 1)) == 32'h0000_0000)
      else $error("gain config reserved bits nonzero");

   // ==========================================
   // Static level checks
   a_card_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_STATIC)
      |=> s.card_lvl == $past(reg_wdata[`RGTC_CARD_MSB:`RGTC_CARD_LSB]))
      else $error("card level write lost");

   a_reader_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_STATIC)
      |=> s.reader_lvl == $past(reg_wdata[`RGTC_READER_MSB:`RGTC_READER_LSB]))
      else $error("reader level write lost");

   a_static_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(reg_wr && hit(reg_addr, `RGTC_OFF_STATIC))
      |=> $stable({s.reader_lvl, s.card_lvl}))
      else $error("static levels changed without write");

   a_static_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_STATIC)
      |=> reg_rdata[`RGTC_READER_MSB:`RGTC_CARD_LSB] == $past({s.reader_lvl, s.card_lvl}))
      else $error("static levels read wrong");

   a_static_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_STATIC)
      |=> (reg_rdata >> (`RGTC_READER_MSB + 1)) == 32'h0000_0000)
      else $error("static upper bits nonzero");

   // ==========================================
   // Transmitter control checks
   a_drv_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> load_mod_driver_select == $past(reg_wdata[`RGTC_TX_DRV]))
      else $error("driver select write lost");

   a_amp_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> s.tx.amp == $past(reg_wdata[`RGTC_TX_AMP_MSB:`RGTC_TX_AMP_LSB]))
      else $error("amplitude write lost");

   a_amp_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.tx.force_max
      |=> card_carrier_amplitude == $past(s.tx.amp))
      else $error("amplitude field not applied");

   a_ovp_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> overshoot_residual_level == $past(reg_wdata[`RGTC_TX_OVP_MSB:`RGTC_TX_OVP_LSB]))
      else $error("overshoot residual write lost");

   a_force_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> s.tx.force_max == $past(reg_wdata[`RGTC_TX_FORCE]))
      else $error("force max write lost");

   a_res_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> residual_level == $past(reg_wdata[`RGTC_TX_RES_MSB:`RGTC_TX_RES_LSB]))
      else $error("residual level write lost");

   a_bypass_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> shaping_bypass == $past(reg_wdata[`RGTC_TX_BYPASS]))
      else $error("bypass write lost");

   a_tau_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.tx.bypass
      |=> tau_effective == $past(rising_edge_tau))
      else $error("rising tau not applied");

   a_tx_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(reg_wr && hit(reg_addr, `RGTC_OFF_TXCTL))
      |=> $stable(s.tx))
      else $error("tx control changed without write");

   a_tx_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> reg_rdata == $past(tx_word(s.tx)))
      else $error("tx control read wrong");

   a_tx_read_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> (reg_rdata >> (`RGTC_TX_DRV + 1)) == 32'h0000_0000)
      else $error("tx control upper bits nonzero");

   a_tx_read_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> reg_rdata[`RGTC_TX_BYPASS-1:0] == '0)
      else $error("tx control low bits nonzero");

   // ==========================================
   // Read port checks
   a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !reg_rd
      |=> reg_rdata == 32'h0000_0000)
      else $error("read data without read strobe");

   a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && !hit(reg_addr, `RGTC_OFF_GAIN_CFG) && !hit(reg_addr, `RGTC_OFF_STATIC)
      && !hit(reg_addr, `RGTC_OFF_TXCTL)
      |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
endmodule

//--- testbench.sv
// Self-checking testbench for the gain divider and carrier registers
`timescale 1ns/10ps
`include "rgtc_cfg.svh"
module testbench;
   import rgtc_pkg::*;
   // ==========================================
   // Signals and design
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [9:0] loop_divider = 10'h000;
   logic [9:0] rx_divider;
   logic gain_loop_enable;
   logic [3:0] rising_edge_tau = 4'h5;
   logic [3:0] tau_effective;
   logic shaping_bypass;
   logic load_mod_driver_select;
   logic [1:0] card_carrier_amplitude;
   logic [4:0] residual_level;
   logic [4:0] overshoot_residual_level;
   int n_fail = 0;
   int num_checks = 0;
   always #5 core_clk = ~core_clk;
   rgtc_regs rgtc_regs_i (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .loop_divider, .rx_divider, .gain_loop_enable, .rising_edge_tau,
      .tau_effective, .shaping_bypass, .load_mod_driver_select, .card_carrier_amplitude,
      .residual_level, .overshoot_residual_level);
   // ==========================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // Derived outputs lag the register by one more cycle
   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      rd(`RGTC_OFF_STATIC, 32'h0);
      rd(`RGTC_OFF_TXCTL, 32'h0);
      rd(`RGTC_OFF_GAIN_CFG, 32'h0);
   endtask
   task automatic t_static();
      wr(`RGTC_OFF_STATIC, 32'hffffffff);
      rd(`RGTC_OFF_STATIC, 32'h000fffff);
      wr(`RGTC_OFF_STATIC, 32'h000aa955);
      rd(`RGTC_OFF_STATIC, 32'h000aa955);
   endtask
   task automatic t_load();
      wr(`RGTC_OFF_GAIN_CFG, 32'h4);
      settle();
      chk({22'h0, rx_divider}, 32'h155);
      rd(`RGTC_OFF_GAIN_CFG, 32'h0);
      wr(`RGTC_OFF_GAIN_CFG, 32'hfffffffc);
      rd(`RGTC_OFF_GAIN_CFG, 32'h8);
      settle();
      chk({22'h0, rx_divider}, 32'h2aa);
      wr(`RGTC_OFF_GAIN_CFG, 32'h0);
      settle();
      chk({22'h0, rx_divider}, 32'h2aa);
      wr(`RGTC_OFF_GAIN_CFG, 32'h4);
      settle();
      chk({22'h0, rx_divider}, 32'h155);
   endtask
   task automatic t_frozen();
      loop_divider <= 10'h3c3;
      wr(`RGTC_OFF_GAIN_CFG, 32'h1);
      settle();
      chk({31'h0, gain_loop_enable}, 32'h1);
      wr(`RGTC_OFF_GAIN_CFG, 32'h2);
      loop_divider <= 10'h00f;
      wr(`RGTC_OFF_GAIN_CFG, 32'h6);
      settle();
      chk({31'h0, gain_loop_enable}, 32'h0);
      chk({22'h0, rx_divider}, 32'h3c3);
   endtask
   task automatic t_tx();
      wr(`RGTC_OFF_TXCTL, 32'hffffffff);
      rd(`RGTC_OFF_TXCTL, 32'h07fff000);
      settle();
      chk({28'h0, tau_effective}, 32'hf);
      chk({31'h0, shaping_bypass}, 32'h1);
      chk({31'h0, load_mod_driver_select}, 32'h1);
      chk({27'h0, residual_level}, 32'h1f);
      wr(`RGTC_OFF_TXCTL, 32'h0152a000);
      settle();
      chk({28'h0, tau_effective}, 32'h5);
      chk({30'h0, card_carrier_amplitude}, 32'h1);
      chk({27'h0, overshoot_residual_level}, 32'h0a);
      chk({27'h0, residual_level}, 32'h15);
      chk({31'h0, load_mod_driver_select}, 32'h0);
      wr(`RGTC_OFF_TXCTL, 32'h0156a000);
      settle();
      chk({30'h0, card_carrier_amplitude}, 32'h3);
      rd(8'h40, 32'h0);
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_static();
      t_load();
      t_frozen();
      t_tx();
      tally_and_finish();
   end
   initial
   begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
endmodule
